/* File: rtl/sct_pkg.sv */
// Package of constants for the stop condition trigger block
package sct_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] ctrl_offset   = 4'h0;
    localparam logic [3:0] status_offset = 4'h4;
    localparam logic [3:0] event_offset  = 4'h8;
    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int stop_trigger_bit          = 0;
    localparam int start_trigger_bit         = 1;
    localparam int ack_generate_enable_bit   = 2;
    localparam int wait_timing_select_bit    = 3;
    localparam int wait_release_bit          = 5;
    localparam int communication_exit_bit    = 6;
    localparam int interface_enable_bit      = 7;
    // ----------------------------------------
    // Status register fields and control reset value
    // ----------------------------------------
    localparam int transmit_mode_flag_bit    = 3;
    localparam int master_status_bit         = 7;
    localparam int stop_busy_bit             = 0;
    localparam logic [7:0] ctrl_reset        = 8'h00;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int clk_mhz                   = 50;
    localparam int stop_setup_ns             = 4000;
    localparam int stop_setup_cycles         = (stop_setup_ns * clk_mhz + 999) / 1000;
    localparam logic [7:0] stop_setup_count  = 8'(stop_setup_cycles);
    // ----------------------------------------
    // Stop sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        st_idle     = 2'b00,
        st_sda_low  = 2'b01,
        st_scl_high = 2'b10,
        st_setup    = 2'b11
    } sct_state_type;
endpackage : sct_pkg

/* File: rtl/sct_timer.sv */
// Setup time counter for the stop condition
`timescale 1ns/10ps
`default_nettype none
module sct_timer
    import sct_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic       run,
    output logic            done
);
    logic [7:0] count;
    logic [7:0] next_count;

    always_comb begin
        if (start) begin
            next_count = stop_setup_count;
        end else if (run && count != 8'h00) begin
            next_count = count - 8'h01;
        end else begin
            next_count = count;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= 8'h00;
        end else begin
            count <= next_count;
        end
    end

    assign done = run && !start && count == 8'h01;
endmodule : sct_timer
`default_nettype wire

/* File: rtl/sct_stop_gen.sv */
// Stop sequencer that drives the two bus lines
`timescale 1ns/10ps
`default_nettype none
module sct_stop_gen
    import sct_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic       abort,
    input  wire logic       scl_in,
    output logic            sda_low,
    output logic            scl_low,
    output logic            busy,
    output logic            done
);
    sct_state_type state;
    sct_state_type next_state;
    logic          tstart;
    logic          tdone;

    sct_timer u_timer (
        .clk   (clk),
        .rst   (rst),
        .start (tstart),
        .run   (state == st_setup),
        .done  (tdone)
    );

    always_comb begin
        next_state = state;
        tstart     = 1'b0;
        done       = 1'b0;
        case (state)
            st_idle: begin
                if (go) begin
                    next_state = st_sda_low;
                end
            end
            st_sda_low: begin
                next_state = st_scl_high;
            end
            st_scl_high: begin
                if (scl_in) begin
                    next_state = st_setup;
                    tstart     = 1'b1;
                end
            end
            st_setup: begin
                if (tdone) begin
                    next_state = st_idle;
                    done       = 1'b1;
                end
            end
            default: next_state = st_idle;
        endcase
        if (abort) begin
            next_state = st_idle;
            done       = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    assign sda_low = state != st_idle;
    assign scl_low = state == st_sda_low;
    assign busy    = state != st_idle;
endmodule : sct_stop_gen
`default_nettype wire

/* File: rtl/sct_ctrl.sv */
// Stop condition trigger control with register port
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sct_ctrl
    import sct_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       arb_lost,
    input  wire logic       ninth_clock,
    input  wire logic       in_wait,
    input  wire logic       master_mode,
    input  wire logic       transmit_set,
    output logic            scl_out,
    output logic            scl_oe_n,
    output logic            sda_out,
    output logic            sda_oe_n,
    output logic            stop_detected,
    output logic            start_trigger,
    output logic            wait_timing_select,
    output logic            ack_generate_enable,
    output logic            communication_exit
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic       stop_trigger;
    logic       next_stop_trigger;
    logic       transmit_mode_flag;
    logic       next_transmit_mode_flag;
    logic       sda_release;
    logic       next_sda_release;
    logic       stop_seen;
    logic       next_stop_seen;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] next_rdata;
    logic       gen_busy;
    logic       gen_done;
    logic       gen_sda_low;
    logic       gen_scl_low;
    logic       ctrl_wr;
    logic       enable;
    logic       stop_armed;
    logic       next_stop_armed;
    logic [7:0] hold_count;
    logic [7:0] next_hold_count;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = a == off;
    endfunction : hit

    function automatic logic stop_request(input logic [7:0] d);
        stop_request = d[stop_trigger_bit] && d[interface_enable_bit];
    endfunction : stop_request

    assign ctrl_wr = wr && hit(addr, ctrl_offset);
    assign enable  = ctrl[interface_enable_bit];

    // ----------------------------------------
    // Stop sequencer
    // ----------------------------------------
    sct_stop_gen u_gen (
        .clk     (clk),
        .rst     (rst),
        .go      (stop_armed && stop_trigger && !gen_busy),
        .abort   (!stop_trigger),
        .scl_in  (scl_in),
        .sda_low (gen_sda_low),
        .scl_low (gen_scl_low),
        .busy    (gen_busy),
        .done    (gen_done)
    );

    // ----------------------------------------
    // Control and trigger next values
    // ----------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_wr) begin
            next_ctrl = wdata;
            next_ctrl[stop_trigger_bit]  = 1'b0;
            next_ctrl[wait_release_bit]  = 1'b0;
        end
        if (arb_lost || (ctrl_wr && wdata[communication_exit_bit])) begin
            next_ctrl[start_trigger_bit] = 1'b0;
        end
        next_ctrl[communication_exit_bit] = 1'b0;
        if (!next_ctrl[interface_enable_bit]) begin
            next_ctrl[start_trigger_bit] = 1'b0;
        end
        // Trigger set by write, cleared by the listed events
        next_stop_trigger = stop_trigger;
        if (ctrl_wr) begin
            next_stop_trigger = stop_request(wdata);
        end
        if (arb_lost || stop_seen || (ctrl_wr && wdata[communication_exit_bit])) begin
            next_stop_trigger = 1'b0;
        end
        if (!enable && !(ctrl_wr && wdata[interface_enable_bit])) begin
            next_stop_trigger = 1'b0;
        end
    end

    // ----------------------------------------
    // Stop launch, once per trigger write
    // ----------------------------------------
    always_comb begin
        next_stop_armed = stop_armed && !gen_busy;
        if (ctrl_wr && stop_request(wdata)) begin
            next_stop_armed = 1'b1;
        end
        if (!next_stop_trigger) begin
            next_stop_armed = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stop_armed <= 1'b0;
        end else begin
            stop_armed <= next_stop_armed;
        end
    end

    // ----------------------------------------
    // Bus line monitor and transmit flag
    // ----------------------------------------
    always_comb begin
        next_stop_seen = enable && scl_q && scl_in && !sda_q && sda_in;
        next_transmit_mode_flag = transmit_mode_flag;
        next_sda_release = sda_release;
        // Wait release in ninth clock clears the transmit flag and sets sda_release
        if (transmit_mode_flag && ctrl_wr && wdata[wait_release_bit] && ninth_clock) begin
            next_transmit_mode_flag = 1'b0;
            next_sda_release = 1'b1;
        end
        // Set wins over a release in the same cycle
        if (transmit_set) begin
            next_transmit_mode_flag = 1'b1;
            next_sda_release = 1'b0;
        end
        if (!enable || arb_lost) begin
            next_transmit_mode_flag = 1'b0;
        end
    end

    // ----------------------------------------
    // Read data; trigger reads as zero
    // ----------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        if (rd && hit(addr, ctrl_offset)) begin
            next_rdata = ctrl;
            next_rdata[stop_trigger_bit] = 1'b0;
        end else if (rd && hit(addr, status_offset)) begin
            next_rdata[transmit_mode_flag_bit] = transmit_mode_flag;
            next_rdata[master_status_bit]      = master_mode;
            next_rdata[stop_busy_bit]          = gen_busy;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl               <= ctrl_reset;
            stop_trigger       <= 1'b0;
            transmit_mode_flag <= 1'b0;
            sda_release        <= 1'b0;
            stop_seen          <= 1'b0;
            scl_q              <= 1'b1;
            sda_q              <= 1'b1;
            rdata              <= 8'h00;
        end else begin
            ctrl               <= next_ctrl;
            stop_trigger       <= next_stop_trigger;
            transmit_mode_flag <= next_transmit_mode_flag;
            sda_release        <= next_sda_release;
            stop_seen          <= next_stop_seen;
            scl_q              <= scl_in;
            sda_q              <= sda_in;
            rdata              <= next_rdata;
        end
    end

    // ----------------------------------------
    // Pins: stop drives SDA low then releases it
    // ----------------------------------------
    // With eight clock wait the ninth high phase may carry the stop
    assign scl_out  = 1'b0;
    assign scl_oe_n = !(gen_scl_low && enable);
    assign sda_out  = 1'b0;
    assign sda_oe_n = !(gen_sda_low && enable);

    assign stop_detected       = stop_seen;
    assign start_trigger       = ctrl[start_trigger_bit];
    assign wait_timing_select  = ctrl[wait_timing_select_bit];
    assign ack_generate_enable = ctrl[ack_generate_enable_bit];
    assign communication_exit  = ctrl_wr && wdata[communication_exit_bit];

    // ----------------------------------------
    // Setup hold counter for the checks
    // ----------------------------------------
    always_comb begin
        next_hold_count = 8'h00;
        if (gen_sda_low && !gen_scl_low && scl_in) begin
            next_hold_count = hold_count;
            if (hold_count != 8'hff) begin
                next_hold_count = hold_count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_count <= 8'h00;
        end else begin
            hold_count <= next_hold_count;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    no_stop_idle_a: assert property (@(posedge clk) disable iff (rst)
        !stop_trigger && !gen_busy |=> sda_oe_n)
        else $error("SDA driven with no stop pending");
    clear_on_arb_a: assert property (@(posedge clk) disable iff (rst)
        arb_lost |=> !stop_trigger)
        else $error("Trigger kept after arbitration loss");
    clear_on_stop_a: assert property (@(posedge clk) disable iff (rst)
        stop_seen |=> !stop_trigger)
        else $error("Trigger kept after stop seen");
    clear_on_wr_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_wr && !wdata[stop_trigger_bit] |=> !stop_trigger)
        else $error("Trigger kept after write of zero");
    read_zero_a: assert property (@(posedge clk) disable iff (rst)
        rd && hit(addr, ctrl_offset) |=> !rdata[stop_trigger_bit])
        else $error("Trigger read back as one");
    release_sda_a: assert property (@(posedge clk) disable iff (rst)
        transmit_mode_flag && ctrl_wr && wdata[wait_release_bit] && ninth_clock
        && !transmit_set |=> !transmit_mode_flag && sda_release)
        else $error("Transmit flag not cleared on release");
    setup_time_a: assert property (@(posedge clk) disable iff (rst)
        $rose(gen_done) |-> $past(gen_sda_low, 2) && scl_in)
        else $error("Stop finished without setup phase");
    exit_clear_a: assert property (@(posedge clk) disable iff (rst)
        communication_exit |=> !stop_trigger && !start_trigger)
        else $error("Exit did not clear triggers");
    scl_pulse_a: assert property (@(posedge clk) disable iff (rst)
        gen_scl_low |=> !gen_scl_low)
        else $error("SCL held low for more than one cycle");
    hold_low_a: assert property (@(posedge clk) disable iff (rst)
        gen_busy && !gen_scl_low && !scl_in && !gen_done && stop_trigger |=> gen_sda_low)
        else $error("SDA released while SCL still low");
    setup_hold_a: assert property (@(posedge clk) disable iff (rst)
        $fell(gen_sda_low) && $past(gen_done) |-> hold_count >= stop_setup_count)
        else $error("Stop setup time too short");
    launch_once_a: assert property (@(posedge clk) disable iff (rst)
        (gen_done && !ctrl_wr) ##1 !ctrl_wr |=> !gen_busy)
        else $error("Stop sequence started again without a write");
    abort_idle_a: assert property (@(posedge clk) disable iff (rst)
        !stop_trigger |=> !gen_busy)
        else $error("Stop sequence kept after trigger clear");
    clear_on_off_a: assert property (@(posedge clk) disable iff (rst)
        !enable && !(ctrl_wr && wdata[interface_enable_bit]) |=> !stop_trigger)
        else $error("Trigger kept while disabled");
    flag_set_a: assert property (@(posedge clk) disable iff (rst)
        transmit_set && enable && !arb_lost |=> transmit_mode_flag)
        else $error("Transmit flag not set");
    flag_keep_a: assert property (@(posedge clk) disable iff (rst)
        transmit_mode_flag && !ninth_clock && enable && !arb_lost |=> transmit_mode_flag)
        else $error("Transmit flag cleared outside the ninth clock");
    enable_bit_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_wr |=> enable == $past(wdata[interface_enable_bit]))
        else $error("Enable bit not taken from bit seven");
    read_ctrl_a: assert property (@(posedge clk) disable iff (rst)
        rd && hit(addr, ctrl_offset) |=> rdata[7:1] == $past(ctrl[7:1]))
        else $error("Control register read back wrong");
    stop_done_c: cover property (@(posedge clk) disable iff (rst) gen_done);
    release_c: cover property (@(posedge clk) disable iff (rst) $rose(sda_release));
    arb_abort_c: cover property (@(posedge clk) disable iff (rst) gen_busy && arb_lost);
    wait_stop_c: cover property (@(posedge clk) disable iff (rst)
        stop_trigger && in_wait && !wait_timing_select);
    exit_abort_c: cover property (@(posedge clk) disable iff (rst)
        gen_busy && communication_exit);
endmodule : sct_ctrl
`default_nettype wire

/* File: dv/sct_bus_model.sv */
// Slave side model of the two bus lines with pull-ups and clock stretching
`timescale 1ns/10ps
`default_nettype none
module sct_bus_model (
    input  wire logic scl_oe_n,
    input  wire logic sda_oe_n,
    input  wire logic stretch,
    output logic      scl,
    output logic      sda
);
    // ----------------------------------------
    // Open-drain wires with pull-ups
    // ----------------------------------------
    // Slow slave holds the clock line low while stretch is high
    assign scl = scl_oe_n & ~stretch;
    assign sda = sda_oe_n;
endmodule : sct_bus_model
`default_nettype wire

/* File: dv/i2c_stop_condition_trigger_tb.sv */
// Testbench for the stop condition trigger block
`timescale 1ns/10ps
`default_nettype none
module i2c_stop_condition_trigger_tb;
    import sct_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       arb_lost = 1'b0;
    logic       ninth_clock = 1'b0;
    logic       in_wait = 1'b1;
    logic       master_mode = 1'b1;
    logic       transmit_set = 1'b0;
    logic       stretch = 1'b0;
    logic       scl;
    logic       sda;
    logic       scl_oe_n;
    logic       sda_oe_n;
    logic       stop_detected;
    logic       start_trigger;
    logic       wait_timing_select;
    logic       ack_generate_enable;
    logic       communication_exit;
    logic       exit_seen = 1'b0;
    int         errors = 0;
    int         n_tests = 0;
    int         cnt;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (communication_exit === 1'b1) begin
            exit_seen <= 1'b1;
        end
    end
    sct_ctrl dut_u (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .scl_in(scl), .sda_in(sda), .arb_lost(arb_lost),
        .ninth_clock(ninth_clock), .in_wait(in_wait), .master_mode(master_mode),
        .transmit_set(transmit_set), .scl_out(), .scl_oe_n(scl_oe_n), .sda_out(),
        .sda_oe_n(sda_oe_n), .stop_detected(stop_detected),
        .start_trigger(start_trigger), .wait_timing_select(wait_timing_select),
        .ack_generate_enable(ack_generate_enable),
        .communication_exit(communication_exit)
    );
    sct_bus_model bus_u (
        .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .stretch(stretch),
        .scl(scl), .sda(sda)
    );
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic complete_run;
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : expect_reg
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        expect_reg(ctrl_offset, ctrl_reset);
        expect_reg(status_offset, 8'h80);
        check({7'h0, sda_oe_n}, 8'h01);
        expect_reg(4'hc, 8'h00);
        // Full stop with a slow slave in the eight-clock wait
        @(posedge clk);
        stretch <= 1'b1;
        wr_reg(ctrl_offset, 8'h81);
        tick(1);
        check({7'h0, scl_oe_n}, 8'h00);
        tick(19);
        check({7'h0, sda_oe_n}, 8'h00);
        check({7'h0, scl_oe_n}, 8'h01);
        expect_reg(ctrl_offset, 8'h80);
        expect_reg(status_offset, 8'h81);
        @(posedge clk);
        stretch <= 1'b0;
        cnt = 0;
        while (sda_oe_n !== 1'b1 && cnt < 1000) begin
            tick(1);
            cnt++;
        end
        check({7'h0, cnt >= stop_setup_cycles && cnt <= stop_setup_cycles + 4}, 8'h01);
        cnt = 0;
        while (stop_detected !== 1'b1 && cnt < 8) begin
            tick(1);
            cnt++;
        end
        check({7'h0, stop_detected}, 8'h01);
        expect_reg(status_offset, 8'h80);
        // Write of zero, arbitration loss, exit and disable each abort a pending stop
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            stretch <= 1'b1;
            wr_reg(ctrl_offset, 8'h88);
            wr_reg(ctrl_offset, 8'h89);
            tick(4);
            case (k)
                0: wr_reg(ctrl_offset, 8'h80);
                1: begin
                    @(posedge clk);
                    arb_lost <= 1'b1;
                    @(posedge clk);
                    arb_lost <= 1'b0;
                end
                2: wr_reg(ctrl_offset, 8'hc0);
                default: wr_reg(ctrl_offset, 8'h00);
            endcase
            tick(2);
            check({7'h0, sda_oe_n}, 8'h01);
            expect_reg(status_offset, 8'h80);
        end
        check({7'h0, exit_seen}, 8'h01);
        @(posedge clk);
        stretch <= 1'b0;
        // Control bit layout
        wr_reg(ctrl_offset, 8'h8e);
        tick(1);
        check({5'h0, start_trigger, wait_timing_select, ack_generate_enable}, 8'h07);
        expect_reg(ctrl_offset, 8'h8e);
        wr_reg(ctrl_offset, 8'hcc);
        tick(1);
        check({5'h0, start_trigger, wait_timing_select, ack_generate_enable}, 8'h03);
        // Wait release clears the transmit flag only in the ninth clock
        @(posedge clk);
        transmit_set <= 1'b1;
        @(posedge clk);
        transmit_set <= 1'b0;
        expect_reg(status_offset, 8'h88);
        wr_reg(ctrl_offset, 8'ha0);
        expect_reg(status_offset, 8'h88);
        @(posedge clk);
        ninth_clock <= 1'b1;
        wr_reg(ctrl_offset, 8'ha0);
        expect_reg(status_offset, 8'h80);
        check({7'h0, sda_oe_n}, 8'h01);
        // Flag set and wait release in one cycle with the flag already clear: the flag is set
        @(posedge clk);
        transmit_set <= 1'b1;
        addr         <= ctrl_offset;
        wdata        <= 8'ha0;
        wr           <= 1'b1;
        @(posedge clk);
        transmit_set <= 1'b0;
        wr           <= 1'b0;
        expect_reg(status_offset, 8'h88);
        @(posedge clk);
        master_mode <= 1'b0;
        expect_reg(status_offset, 8'h08);
        complete_run();
    end
    initial begin
        #1000000;
        errors++;
        complete_run();
    end
endmodule : i2c_stop_condition_trigger_tb
`default_nettype wire
